// file: osd_defines.vh
`ifndef OSD_DEFINES_VH
`define OSD_DEFINES_VH
// ==========================================================
// widths
`define OSD_NCH 8
`define OSD_MSB 7
// ==========================================================
// reset values
`define OSD_LATCH_RST 8'hff
`define OSD_SHIFT_RST 8'h00
`define OSD_SO_RST 1'b0
// ==========================================================
// timing
`define OSD_CLK_MHZ 125
`define OSD_BLANK_US 160
`define OSD_BLANK_CYC (`OSD_BLANK_US * `OSD_CLK_MHZ)
`define OSD_CNT_W 15
`define OSD_SYNC_STAGES 2
`endif

// file: osd_sync.v
`timescale 1ns/100ps
// ==========================================================
// two-flop synchroniser, first stage feeds only the second
module osd_sync #(
  parameter WIDTH = 1
) (
  input wire clk,
  input wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  always @(posedge clk) begin
    meta_r <= d;
    sync_r <= meta_r;
  end

  assign q = sync_r;
endmodule // osd_sync

// file: osd_port.v
`timescale 1ns/100ps
// Functional notes
// - serial output enabled only while select is low, high impedance otherwise.
// - each of the first eight shifted-out bits is one when its output pin is sensed high.
// - reset pin turns drive off, sets every latch bit and clears the shift register at once, clock independent.
// - channel seven goes first, channel zero last, in both directions.
// - select rising edge copies shift register into the output latch.
// - select falling edge loads shift register with the eight sensed levels.
// - while selected, next bit appears on serial output after each shift clock rise.
// - while selected, serial input is sampled on each shift clock fall.
// - control bit one means output off, zero means output on.
// - shift register and control word are eight bits, one per channel.
// - fault clearing suppressed during blanking delay started at select rise.
// - data flows serial in to serial out unbounded, allowing daisy chains.
// - shift clock ignored completely while select is high.
// - after blanking, an on channel still sensed high gets its latch bit set off.
// - reset sets the whole output latch to ones, turning all eight outputs off.
`include "osd_defines.vh"

module osd_port #(
  parameter BLANK_CYCLES = `OSD_BLANK_CYC
) (
  input wire clk,
  input wire rst_n,
  input wire drv_reset_n,
  input wire cs_n,
  input wire sclk,
  input wire si,
  input wire [`OSD_MSB:0] out_sensed_high,
  output reg so_o,
  output reg so_oe,
  output reg [`OSD_MSB:0] out_off_r,
  output reg blank_busy_r
);

  // ==========================================================
  // reset pin synchroniser
  // asserts at once with no clock, releases two clocks later so that
  // every flop leaves reset on the same edge
  reg drv_rst_meta_r;
  reg drv_rst_sync_r;
  wire drv_rst_n_s;

  always @(posedge clk or negedge drv_reset_n) begin
    if (!drv_reset_n) begin
      drv_rst_meta_r <= 1'b0;
      drv_rst_sync_r <= 1'b0;
    end else begin
      drv_rst_meta_r <= 1'b1;
      drv_rst_sync_r <= drv_rst_meta_r;
    end
  end

  assign drv_rst_n_s = drv_rst_sync_r;

  // ==========================================================
  // pin synchronisers
  wire cs_n_s;
  wire sclk_s;
  wire si_s;
  wire [`OSD_MSB:0] sensed_s;

  osd_sync #(
    .WIDTH(3)
  ) u_sync_ctl (
    .clk(clk),
    .d({cs_n, sclk, si}),
    .q({cs_n_s, sclk_s, si_s})
  );

  // comparator flags arrive asynchronously from the output stages
  osd_sync #(
    .WIDTH(`OSD_NCH)
  ) u_sync_sense (
    .clk(clk),
    .d(out_sensed_high),
    .q(sensed_s)
  );

  // ==========================================================
  // edge decode shared by select and shift clock
  // previous and current synchronised level in, one-cycle pulse out
  function edge_up;
    input prev_lvl;
    input curr_lvl;
    begin
      edge_up = ~prev_lvl & curr_lvl;
    end
  endfunction

  function edge_down;
    input prev_lvl;
    input curr_lvl;
    begin
      edge_down = prev_lvl & ~curr_lvl;
    end
  endfunction

  // ==========================================================
  // edge detection on synchronised pins
  reg cs_n_d_r;
  reg sclk_d_r;
  wire selected;
  wire cs_fall;
  wire cs_rise;
  wire sclk_rise;
  wire sclk_fall;

  always @(posedge clk) begin
    if (!rst_n) begin
      cs_n_d_r <= 1'b1;
      sclk_d_r <= 1'b0;
    end else begin
      cs_n_d_r <= cs_n_s;
      sclk_d_r <= sclk_s;
    end
  end

  assign selected = ~cs_n_s;
  assign cs_fall = edge_down(cs_n_d_r, cs_n_s);
  assign cs_rise = edge_up(cs_n_d_r, cs_n_s);
  // clock edges count only while selected; gating here keeps idle
  // shift clock activity from disturbing the shift register
  assign sclk_rise = selected & ~cs_fall & edge_up(sclk_d_r, sclk_s);
  assign sclk_fall = selected & ~cs_fall & edge_down(sclk_d_r, sclk_s);

  // ==========================================================
  // shift register and serial output
  reg [`OSD_MSB:0] shift_r;

  // the pin reset is asynchronous so it clears even with no clock
  always @(posedge clk or negedge drv_rst_n_s) begin
    if (!drv_rst_n_s) begin
      shift_r <= `OSD_SHIFT_RST;
    end else if (!rst_n) begin
      shift_r <= `OSD_SHIFT_RST;
    end else if (cs_fall) begin
      shift_r <= sensed_s;
    end else if (sclk_fall) begin
      shift_r <= {shift_r[`OSD_MSB-1:0], si_s};
    end
  end

  always @(posedge clk or negedge drv_rst_n_s) begin
    if (!drv_rst_n_s) begin
      so_o <= `OSD_SO_RST;
      so_oe <= 1'b0;
    end else if (!rst_n) begin
      so_o <= `OSD_SO_RST;
      so_oe <= 1'b0;
    end else begin
      so_oe <= selected;
      if (sclk_rise) begin
        so_o <= shift_r[`OSD_MSB];
      end
    end
  end

  // ==========================================================
  // blanking timer
  reg [`OSD_CNT_W-1:0] blank_cnt_r;
  reg [`OSD_CNT_W-1:0] blank_cnt_nxt;
  reg blank_busy_nxt;
  // the count must fit the counter; 20000 cycles at 125 MHz is 160 us
  localparam [31:0] BLANK_LAST_W = BLANK_CYCLES - 1;
  localparam [`OSD_CNT_W-1:0] BLANK_LAST = BLANK_LAST_W[`OSD_CNT_W-1:0];
  localparam [`OSD_CNT_W-1:0] CNT_ONE = {{(`OSD_CNT_W-1){1'b0}}, 1'b1};

  always @* begin
    blank_cnt_nxt = blank_cnt_r;
    blank_busy_nxt = blank_busy_r;
    if (cs_rise) begin
      blank_cnt_nxt = BLANK_LAST;
      blank_busy_nxt = 1'b1;
    end else if (blank_busy_r) begin
      if (blank_cnt_r == {`OSD_CNT_W{1'b0}}) begin
        blank_busy_nxt = 1'b0;
      end else begin
        blank_cnt_nxt = blank_cnt_r - CNT_ONE;
      end
    end
  end

  always @(posedge clk or negedge drv_rst_n_s) begin
    if (!drv_rst_n_s) begin
      blank_cnt_r <= {`OSD_CNT_W{1'b0}};
      blank_busy_r <= 1'b0;
    end else if (!rst_n) begin
      blank_cnt_r <= {`OSD_CNT_W{1'b0}};
      blank_busy_r <= 1'b0;
    end else begin
      blank_cnt_r <= blank_cnt_nxt;
      blank_busy_r <= blank_busy_nxt;
    end
  end

  // ==========================================================
  // output latch with per-channel fault clearing
  // a fault only ever turns a channel off; a new frame can turn it back on
  localparam [`OSD_MSB:0] LATCH_RST = `OSD_LATCH_RST;
  genvar ch;
  generate
    for (ch = 0; ch < `OSD_NCH; ch = ch + 1) begin : g_ch
      wire fault_hit;
      // on channel whose pin stays high after blanking is overloaded
      assign fault_hit = ~blank_busy_r & ~cs_rise & ~out_off_r[ch] & sensed_s[ch];

      always @(posedge clk or negedge drv_rst_n_s) begin
        if (!drv_rst_n_s) begin
          out_off_r[ch] <= LATCH_RST[ch];
        end else if (!rst_n) begin
          out_off_r[ch] <= LATCH_RST[ch];
        end else if (cs_rise) begin
          out_off_r[ch] <= shift_r[ch];
        end else if (fault_hit) begin
          out_off_r[ch] <= 1'b1;
        end
      end
    end
  endgenerate

endmodule // osd_port

// file: osd_host.sv
`timescale 1ns/100ps
// ====
// host master, sclk period 125 ns
module osd_host (
  output logic cs_n,
  output logic sclk,
  output logic si,
  input wire so
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    si = 1'b1;
  end
  // si moves at sclk rise, half a period clear of the sampling fall
  task xfer(input [15:0] w, output [15:0] r);
    cs_n = 1'b0;
    #300;
    for (int i = 15; i >= 0; i--) begin
      si = w[i];
      sclk = 1'b1;
      #62.5 r[i] = so;
      sclk = 1'b0;
      #62.5;
    end
    #300 cs_n = 1'b1;
    #300;
  endtask
  // shift clock toggled while deselected, left low for the next select edge
  task idle_sclk(input int n);
    for (int i = 0; i < n; i++) begin
      sclk = 1'b1;
      #62.5 sclk = 1'b0;
      #62.5;
    end
  endtask
endmodule // osd_host

// file: osd_port_sva.sv
`timescale 1ns/100ps
// ====
// port checker
module osd_port_sva #(
  parameter BLANK_CYCLES = 20
) (
  input wire clk,
  input wire rst_n,
  input wire drv_reset_n,
  input wire cs_n,
  input wire [7:0] out_sensed_high,
  input wire so_oe,
  input wire [7:0] out_off_r,
  input wire blank_busy_r
);
  int cnt_r = 0;
  always @(posedge clk) cnt_r <= blank_busy_r ? cnt_r + 1 : 0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n || !drv_reset_n);
  sequence s_quiet;
    !blank_busy_r && cs_n && $past(cs_n, 4);
  endsequence
  sequence s_on;
    |($past(out_off_r) & ~out_off_r);
  endsequence
  chk_oe_off: assert property (cs_n [*5] |-> !so_oe)
    else $error("oe off");
  chk_oe_on: assert property (!cs_n [*5] |-> so_oe)
    else $error("oe on");
  chk_reset_clear: assert property (disable iff (!rst_n)
    !drv_reset_n |-> out_off_r == 8'hff && !so_oe) else $error("reset pin");
  chk_on_cause: assert property (s_on |-> $past(cs_n, 2))
    else $error("load cause");
  chk_blank_start: assert property (s_on |-> ##[0:1] blank_busy_r)
    else $error("blank start");
  chk_blank_len: assert property ($fell(blank_busy_r) |->
    cnt_r >= BLANK_CYCLES - 1 && cnt_r <= BLANK_CYCLES + 1) else $error("blank len");
  chk_no_clear: assert property (blank_busy_r && $past(blank_busy_r) && $past(cs_n, 8)
    |-> (out_off_r & ~$past(out_off_r)) == 8'h00) else $error("blank clear");
  chk_fault_clear: assert property (s_quiet ##0 (~out_off_r & out_sensed_high) != 8'h00
    |-> ##[1:6] (~out_off_r & out_sensed_high) == 8'h00) else $error("fault clear");
endmodule // osd_port_sva

bind osd_port osd_port_sva #(.BLANK_CYCLES(BLANK_CYCLES)) u_osd_port_sva (.clk, .rst_n,
  .drv_reset_n, .cs_n, .out_sensed_high, .so_oe, .out_off_r, .blank_busy_r);

// file: test_osd_port.sv
`timescale 1ns/100ps
// ====
// bench
module test_osd_port;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic drv_reset_n = 1'b1;
  logic [7:0] sense = 8'h00;
  logic [15:0] rd;
  wire cs_n, sclk, si, so_o, so_oe, blank_busy_r;
  wire [7:0] out_off_r;
  wire so_pin = so_oe ? so_o : 1'bz;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  osd_port #(.BLANK_CYCLES(60)) u_osd_port (.clk, .rst_n, .drv_reset_n, .cs_n, .sclk, .si,
    .out_sensed_high(sense), .so_o, .so_oe, .out_off_r, .blank_busy_r);
  osd_host u_osd_host (.cs_n, .sclk, .si, .so(so_pin));
  task chk(input string nm, input [7:0] exp, input [7:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task complete_run;
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      complete_run;
    end
  end
  task t_reset;
    chk("latch", 8'hff, out_off_r);
    chk("oe", 8'h00, {7'h0, so_oe});
  endtask
  // 16-bit frame: the first byte passes through to so, the last one lands in the latch
  task t_frame;
    @(negedge clk) sense = 8'h0f;
    u_osd_host.xfer(16'h5aa5, rd);
    chk("diag", 8'h0f, rd[15:8]);
    chk("chain", 8'h5a, rd[7:0]);
    chk("latch", 8'ha5, out_off_r);
    chk("busy", 8'h01, {7'h0, blank_busy_r});
    repeat (60) @(negedge clk);
    chk("fault", 8'haf, out_off_r);
  endtask
  // last bit shown was a pass-through zero; idle clocks must not replace it
  task t_idle;
    u_osd_host.idle_sclk(8);
    repeat (4) @(negedge clk);
    chk("so_idle", 8'h00, {7'h0, so_o});
  endtask
  // control byte a5 sent again: sensed byte xor a5 flags 1 and 3 (on, sensed high) and 5 and 7 (off, sensed low)
  task t_diag;
    u_osd_host.xfer(16'h00a5, rd);
    chk("faults", 8'haa, rd[15:8] ^ 8'ha5);
    chk("chain2", 8'h00, rd[7:0]);
    chk("latch2", 8'ha5, out_off_r);
  endtask
  task t_async;
    @(negedge clk) #1 drv_reset_n = 1'b0;
    #1 chk("async", 8'hff, out_off_r);
    repeat (2) @(negedge clk);
    drv_reset_n = 1'b1;
    repeat (4) @(negedge clk);
    chk("rel_latch", 8'hff, out_off_r);
    chk("rel_busy", 8'h00, {7'h0, blank_busy_r});
  endtask
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset;
    t_frame;
    t_idle;
    t_diag;
    t_async;
    complete_run;
  end
endmodule // test_osd_port
